/* line_power_pkg.sv */
`default_nettype none

package line_power_pkg;

    // Channel count and register geometry
    localparam int          NUM_CHANNELS  = 3;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 8;

    // Control register offset and reset value
    localparam logic [7:0]  LPRC_OFFSET   = 8'h00;
    localparam logic [7:0]  LPRC_RESET    = 8'h00;

    // Field positions: receive enables at 6:4, transmit enables at 2:0
    localparam int          RX_EN_LSB     = 4;
    localparam int          TX_EN_LSB     = 0;

    // Writable bits; reserved bits 7 and 3 stay zero
    localparam logic [7:0]  LPRC_RW_MASK  = 8'h77;

    // Depth of the pin synchroniser
    localparam int          SYNC_STAGES   = 3;

    // One register access from the serial interface back end
    typedef struct packed {
        logic [ADDR_W-1:0] addr;   // Register offset
        logic [DATA_W-1:0] wdata;  // Write data
        logic              wr;     // One-cycle write strobe
        logic              rd;     // One-cycle read strobe
    } reg_req_type;

    // Differential line pair as digital polarity levels
    typedef struct packed {
        logic pos;                 // Positive leg
        logic neg;                 // Negative leg
    } line_pair_type;

    // Address match, used by both the write and the read path
    function automatic logic hits_ctrl(input logic [ADDR_W-1:0] addr);
        hits_ctrl = (addr == LPRC_OFFSET);
    endfunction

endpackage

`default_nettype wire

/* tx_driver_gate.sv */
`default_nettype none

// One channel's transmit driver: pin enable and register enable combine
module tx_driver_gate (
    input  wire logic                          clock,
    input  wire logic                          rst,
    input  wire logic                          reg_enable,
    input  wire logic                          transmit_enable_pin,
    input  wire line_power_pkg::line_pair_type tx_data,
    output logic                               driver_on,
    output line_power_pkg::line_pair_type      line_out,
    output logic                               line_out_oe
);

    // Pin synchroniser; stage 0 is read only by stage 1
    logic [line_power_pkg::SYNC_STAGES-1:0] pin_sync_ff;
    logic [line_power_pkg::SYNC_STAGES-1:0] nxt_pin_sync;
    logic                                   pin_level_ff;  // Agreed pin level
    logic                                   nxt_pin_level;

    // Driver state
    logic                                   on_ff;
    logic                                   nxt_on;
    line_power_pkg::line_pair_type          out_ff;
    line_power_pkg::line_pair_type          nxt_out;

    // Next values for synchroniser and driver
    always_comb begin
        nxt_pin_sync  = {pin_sync_ff[line_power_pkg::SYNC_STAGES-2:0], transmit_enable_pin};
        // Level counts only once stages two and three agree, filtering one-cycle glitches
        if (pin_sync_ff[1] == pin_sync_ff[2]) begin
            nxt_pin_level = pin_sync_ff[2];
        end else begin
            nxt_pin_level = pin_level_ff;
        end
        nxt_on = reg_enable & pin_level_ff;
        // Idle driver holds zero pulses so nothing leaks out when re-enabled
        if (nxt_on) begin
            nxt_out = tx_data;
        end else begin
            nxt_out = '0;
        end
    end

    // Register stage; a powered-down driver starts off
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_sync_ff  <= '0;
            pin_level_ff <= 1'b0;
            on_ff        <= 1'b0;
            out_ff       <= '0;
        end else begin
            pin_sync_ff  <= nxt_pin_sync;
            pin_level_ff <= nxt_pin_level;
            on_ff        <= nxt_on;
            out_ff       <= nxt_out;
        end
    end

    // Enable low releases both legs to high impedance
    assign line_out_oe = on_ff;
    assign line_out    = out_ff;
    assign driver_on   = on_ff;

endmodule

`default_nettype wire

/* channel_power_redundancy_control.sv */
// Overview of operation
// - 8-bit register at 0x00, resets zero, reserved read zero
// - Bits 6..4 enable receive sections, channels 2..0
// - Receive enable 1 powers up and accepts line data
// - Receive enable 0 powers whole receive section down
// - Bit 2 turns channel 2 driver on while its transmit enable pin is high
// - Bit 2 low tri-states channel 2 outputs
// - Bits 1,0 enable channel 1,0 drivers likewise
`default_nettype none

module channel_power_redundancy_control (
    input  wire logic                          clock,
    input  wire logic                          rst,
    // Register port from the serial interface back end
    // One-cycle strobes on this clock, so no synchroniser is needed
    input  wire line_power_pkg::reg_req_type   reg_req,
    output logic [line_power_pkg::DATA_W-1:0]  reg_rdata,
    output logic                               reg_rvalid,
    // External per-channel transmit enable pins
    // Asynchronous board levels, each synchronised inside its driver gate
    input  wire logic [line_power_pkg::NUM_CHANNELS-1:0] transmit_enable_pin,
    // Transmit pulse data per channel
    // Already on this clock; passed to the line only while a driver is on
    input  wire line_power_pkg::line_pair_type [line_power_pkg::NUM_CHANNELS-1:0] tx_data,
    // Line outputs with output enables
    // An enable low means the pair is released to high impedance
    output line_power_pkg::line_pair_type [line_power_pkg::NUM_CHANNELS-1:0] line_output,
    output logic [line_power_pkg::NUM_CHANNELS-1:0] line_output_oe,
    output logic [line_power_pkg::NUM_CHANNELS-1:0] transmit_driver_enable,
    // Line inputs from the receive pins
    // Asynchronous levels, synchronised per leg below
    input  wire logic [line_power_pkg::NUM_CHANNELS-1:0] line_input_positive,
    input  wire logic [line_power_pkg::NUM_CHANNELS-1:0] line_input_negative,
    // Receive section power controls and recovered data
    // Both registered; data reads zero while a section is powered down
    output logic [line_power_pkg::NUM_CHANNELS-1:0] receive_section_power_enable,
    output line_power_pkg::line_pair_type [line_power_pkg::NUM_CHANNELS-1:0] rx_data
);

    // Shorthand for the channel count and synchroniser depth
    localparam int NCH = line_power_pkg::NUM_CHANNELS;
    localparam int NST = line_power_pkg::SYNC_STAGES;

    // Next filtered level of one synchronised input: a new level counts
    // only once stages two and three agree, otherwise the held level stays.
    // A spike of a single cycle is dropped this way instead of reaching the
    // recovered data; the price is one more cycle of latency per edge.
    function automatic logic agreed_level(input logic [NST-1:0] sync,
                                          input logic           held);
        if (sync[1] == sync[2]) begin
            agreed_level = sync[2];
        end else begin
            agreed_level = held;
        end
    endfunction

    // Control register and its next value
    // Only the six enable bits can ever hold a one
    logic [7:0]                              ctrl_ff;
    logic [7:0]                              nxt_ctrl;

    // Read answer
    logic [line_power_pkg::DATA_W-1:0]       rdata_ff;
    logic [line_power_pkg::DATA_W-1:0]       nxt_rdata;
    logic                                    rvalid_ff;
    logic                                    nxt_rvalid;

    // Field views of the register
    logic [NCH-1:0]                          rx_on;
    logic [NCH-1:0]                          tx_on;

    // Receive synchronisers per channel and leg
    // Three stages per leg because the line levels arrive from outside
    // this clock domain
    logic [NCH-1:0][NST-1:0]                 rxp_sync_ff;
    logic [NCH-1:0][NST-1:0]                 rxn_sync_ff;
    logic [NCH-1:0][NST-1:0]                 nxt_rxp_sync;
    logic [NCH-1:0][NST-1:0]                 nxt_rxn_sync;

    // Recovered data and power state
    // Both clear while a section is off
    line_power_pkg::line_pair_type [NCH-1:0] rx_data_ff;
    line_power_pkg::line_pair_type [NCH-1:0] nxt_rx_data;
    logic [NCH-1:0]                          rx_pwr_ff;
    logic [NCH-1:0]                          nxt_rx_pwr;

    // Receive enables sit at 6:4 and transmit enables at 2:0, one bit per
    // channel, so each bit acts on its own channel only
    assign rx_on = ctrl_ff[line_power_pkg::RX_EN_LSB +: NCH];
    // Transmit enables feed the driver gates below
    assign tx_on = ctrl_ff[line_power_pkg::TX_EN_LSB +: NCH];

    // Register next value: only mapped, writable bits change
    // A write to any other offset is dropped here; the registers that
    // share the serial interface live outside this block
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (reg_req.wr && line_power_pkg::hits_ctrl(reg_req.addr)) begin
            // Reserved bits are masked so they never store a one
            nxt_ctrl = reg_req.wdata & line_power_pkg::LPRC_RW_MASK;
        end
    end

    // Control register flops
    // Reset clears every enable bit, so all receive sections start
    // powered down and every transmit driver starts in high impedance;
    // nothing reaches the line until software asks for it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_ff <= line_power_pkg::LPRC_RESET;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // Read path: a read in the same cycle as a write sees the old value
    // The answer is registered so the back end sees a clean one-cycle
    // valid pulse; the data then holds until the next read replaces it.
    // Trade-off: one cycle of read latency for a flop-driven bus
    always_comb begin
        nxt_rvalid = reg_req.rd;
        nxt_rdata  = rdata_ff;
        if (reg_req.rd) begin
            if (line_power_pkg::hits_ctrl(reg_req.addr)) begin
                // Masking again keeps reserved bits zero on the bus
                nxt_rdata = ctrl_ff & line_power_pkg::LPRC_RW_MASK;
            end else begin
                // Unmapped offsets answer zero
                nxt_rdata = '0;
            end
        end
    end

    // Read answer flops
    // Cleared read data keeps the bus quiet after reset, and the valid
    // flag never pulses without a read strobe in the cycle before
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_ff  <= '0;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // Both read outputs come straight from their flops
    assign reg_rdata  = rdata_ff;
    assign reg_rvalid = rvalid_ff;

    // Receive sections: power state, synchronisers and recovered data
    // Each channel runs only from its own enable bit, so powering one
    // section down never disturbs the data of its neighbours.
    // Limitation: only the power state and the sampled line levels are
    // modelled here; gain control, equalizer and clock recovery are
    // analog functions that take the power state as their enable and sit
    // outside this block. A section that wakes up needs about four cycles
    // before the first sampled level shows on its data output.
    always_comb begin
        for (int ch = 0; ch < NCH; ch++) begin
            nxt_rx_pwr[ch] = rx_on[ch];
            if (rx_on[ch]) begin
                // Powered: shift the line levels in
                // Stage one is read only by stage two
                nxt_rxp_sync[ch] = {rxp_sync_ff[ch][NST-2:0], line_input_positive[ch]};
                nxt_rxn_sync[ch] = {rxn_sync_ff[ch][NST-2:0], line_input_negative[ch]};
                // A level counts once stages two and three agree
                nxt_rx_data[ch].pos = agreed_level(rxp_sync_ff[ch], rx_data_ff[ch].pos);
                nxt_rx_data[ch].neg = agreed_level(rxn_sync_ff[ch], rx_data_ff[ch].neg);
            end else begin
                // Powered down: whole path held cleared, so stale data never
                // appears when the section wakes up again
                nxt_rxp_sync[ch] = '0;
                nxt_rxn_sync[ch] = '0;
                nxt_rx_data[ch]  = '0;
            end
        end
    end

    // Receive section flops; all sections off after reset
    // Synchronisers clear as well, so no level from before the reset can
    // appear once a section is powered up again
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rxp_sync_ff <= '0;
            rxn_sync_ff <= '0;
            rx_data_ff  <= '0;
            rx_pwr_ff   <= '0;
        end else begin
            rxp_sync_ff <= nxt_rxp_sync;
            rxn_sync_ff <= nxt_rxn_sync;
            rx_data_ff  <= nxt_rx_data;
            rx_pwr_ff   <= nxt_rx_pwr;
        end
    end

    // Power state lags the enable bit by one cycle, so the power state and
    // the cleared data always drop on the same edge
    assign receive_section_power_enable = rx_pwr_ff;
    assign rx_data                      = rx_data_ff;

    // Transmit drivers, one per channel; software control needs the pin held
    // high by the board, otherwise the driver stays off whatever the bit says
    // Each gate synchronises its own pin, so a pin change reaches the line
    // about five cycles after it happens, while a bit change needs only one.
    // The gate registers the pulse levels too, so the enable and the data
    // it qualifies always change on the same edge
    for (genvar ch = 0; ch < NCH; ch++) begin : g_tx
        tx_driver_gate u_drv (
            .clock               (clock),
            .rst                 (rst),
            .reg_enable          (tx_on[ch]),
            .transmit_enable_pin (transmit_enable_pin[ch]),
            .tx_data             (tx_data[ch]),
            .driver_on           (transmit_driver_enable[ch]),
            .line_out            (line_output[ch]),
            .line_out_oe         (line_output_oe[ch])
        );
    end

endmodule

`default_nettype wire

/* channel_power_redundancy_control_properties.sv */
`default_nettype none

// Watches register port and line pins of the power control block
module line_power_properties (
    input wire logic                                clock,
    input wire logic                                rst,
    input wire line_power_pkg::reg_req_type         reg_req,
    input wire logic [7:0]                          reg_rdata,
    input wire logic                                reg_rvalid,
    input wire logic [2:0]                          transmit_enable_pin,
    input wire line_power_pkg::line_pair_type [2:0] line_output,
    input wire logic [2:0]                          line_output_oe,
    input wire logic [2:0]                          transmit_driver_enable,
    input wire logic [2:0]                          receive_section_power_enable,
    input wire line_power_pkg::line_pair_type [2:0] rx_data
);
    // Write to the one mapped offset
    logic wr_hit;
    assign wr_hit = reg_req.wr && (reg_req.addr == 8'h00);

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    chk_read_answer: assert property (reg_req.rd |=> reg_rvalid)
        else $error("read not answered next cycle");
    chk_reserved_zero: assert property (reg_rvalid |-> !reg_rdata[7] && !reg_rdata[3])
        else $error("reserved bit read as one");
    chk_unmapped_zero: assert property (reg_req.rd && reg_req.addr != 8'h00 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_rx_enable_write: assert property (wr_hit |-> ##2
        receive_section_power_enable == $past(reg_req.wdata[6:4], 2))
        else $error("receive power does not follow write");
    chk_tx_bit_off: assert property (wr_hit |-> ##2
        (transmit_driver_enable & ~$past(reg_req.wdata[2:0], 2)) == 3'h0)
        else $error("driver on with its bit clear");
    chk_pin_low_off: assert property (!transmit_enable_pin[2] [*6] |=> !transmit_driver_enable[2])
        else $error("driver on with pin low");
    chk_oe_is_enable: assert property (line_output_oe == transmit_driver_enable)
        else $error("output enable differs from driver state");
    chk_off_lines_zero: assert property ((line_output_oe[0] || line_output[0] == 2'b00)
        && (line_output_oe[1] || line_output[1] == 2'b00)
        && (line_output_oe[2] || line_output[2] == 2'b00))
        else $error("line driven while disabled");
    chk_rx_off_zero: assert property (!receive_section_power_enable[0]
        && !$past(receive_section_power_enable[0]) |-> rx_data[0] == 2'b00)
        else $error("receive data while powered down");

    // Main scenarios reached
    cover property (reg_rvalid);
    cover property (transmit_driver_enable == 3'h3);
    cover property (receive_section_power_enable[2]);
endmodule

bind channel_power_redundancy_control line_power_properties i_chk (
    .clock(clock), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .transmit_enable_pin(transmit_enable_pin),
    .line_output(line_output), .line_output_oe(line_output_oe),
    .transmit_driver_enable(transmit_driver_enable),
    .receive_section_power_enable(receive_section_power_enable), .rx_data(rx_data));

`default_nettype wire

/* channel_power_redundancy_control_tb.sv */
`default_nettype none

module channel_power_redundancy_control_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                                  clock = 1'b0;
    logic                                  rst = 1'b1;
    line_power_pkg::reg_req_type           reg_req = '0;
    logic [7:0]                            reg_rdata;
    logic                                  reg_rvalid;
    logic [2:0]                            pin = 3'h0;      // Transmit enable pins
    line_power_pkg::line_pair_type [2:0]   tx_data = 6'h19; // Channels 0 and 2 get 01, channel 1 gets 10
    line_power_pkg::line_pair_type [2:0]   line_output;
    line_power_pkg::line_pair_type [2:0]   rx_data;
    logic [2:0]                            oe;
    logic [2:0]                            tde;
    logic [2:0]                            rse;
    logic [2:0]                            lin_p = 3'h0;    // Line input levels
    logic [7:0]                            rd_val;          // Last read data
    int                                    n_mismatch = 0;
    int                                    num_checks = 0;

    // 100 MHz clock
    always #5 clock = ~clock;

    channel_power_redundancy_control i_dut (
        .clock(clock), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .transmit_enable_pin(pin), .tx_data(tx_data),
        .line_output(line_output), .line_output_oe(oe), .transmit_driver_enable(tde),
        .line_input_positive(lin_p), .line_input_negative(~lin_p),
        .receive_section_power_enable(rse), .rx_data(rx_data));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Strobe held one cycle, then one idle cycle so it is never re-raised at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(negedge clock);
        reg_req.wr = 1'b0;
        @(negedge clock);
    endtask

    task automatic rd(input logic [7:0] a);
        reg_req.addr = a;
        reg_req.rd = 1'b1;
        @(negedge clock);
        reg_req.rd = 1'b0;
        check(8'(reg_rvalid), 8'h01);
        rd_val = reg_rdata;
        @(negedge clock);
    endtask

    task automatic t_regs();
        rd(8'h00);
        check(rd_val, 8'h00);
        check(8'({oe, rse}), 8'h00);
        wr(8'h00, 8'hff);
        rd(8'h00);
        check(rd_val, 8'h77);
        wr(8'h01, 8'h00);
        rd(8'h01);
        check(rd_val, 8'h00);
        rd(8'h00);
        check(rd_val, 8'h77);
        wr(8'h00, 8'h00);
        $display("test regs done");
    endtask

    // Every channel sees a level so a wrong channel shows up; channel 1
    // gets its negative leg high so both legs of the path are exercised
    task automatic t_rx();
        lin_p = 3'h5;
        for (int ch = 0; ch < 3; ch++) begin
            wr(8'h00, 8'(8'h10 << ch));
            repeat (6) @(negedge clock);
            check(8'(rse), 8'(1 << ch));
            check(8'(rx_data), 8'((lin_p[ch] ? 6'h2 : 6'h1) << 2 * ch));
            wr(8'h00, 8'h00);
            repeat (2) @(negedge clock);
            check(8'(rx_data), 8'h00);
        end
        $display("test rx done");
    endtask

    task automatic t_tx();
        pin = 3'h7;
        for (int ch = 0; ch < 3; ch++) begin
            wr(8'h00, 8'(1 << ch));
            repeat (6) @(negedge clock);
            check(8'({oe, tde}), 8'({2{3'(1 << ch)}}));
            check(8'(line_output), 8'(tx_data & (6'h3 << 2 * ch)));
        end
        wr(8'h00, 8'h07);
        pin = 3'h3;
        repeat (8) @(negedge clock);
        check(8'(oe), 8'h03);
        wr(8'h00, 8'h00);
        repeat (3) @(negedge clock);
        check(8'(oe), 8'h00);
        $display("test tx done");
    endtask

    // Mid-run reset clears the register and every output straight away
    task automatic t_reset();
        wr(8'h00, 8'h77);
        repeat (6) @(negedge clock);
        check(8'({oe, rse}), 8'h1f);
        rst = 1'b1;
        @(negedge clock);
        check(8'({oe, rse}), 8'h00);
        check(8'(rx_data | line_output), 8'h00);
        rst = 1'b0;
        rd(8'h00);
        check(rd_val, 8'h00);
        $display("test reset done");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Tests need well under a thousand cycles
    initial begin
        #20000;
        n_mismatch++;
        summarize();
    end

    initial begin
        repeat (5) @(negedge clock);
        rst = 1'b0;
        t_regs();
        t_rx();
        t_tx();
        t_reset();
        summarize();
    end
endmodule

`default_nettype wire
